// [verilog/t16oc_top.sv]
`timescale 1ns/1ps
`include "t16oc_consts.svh"
module t16oc_top
  import t16oc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            chan_a_wave_out,
  output logic            chan_b_wave_out,
  output logic            chan_a_pin_takeover,
  output logic            chan_b_pin_takeover,
  output logic            timer_irq
);

  logic [1:0]   chan_a_output_action;  // Channel A action field.
  logic [1:0]   chan_b_output_action;  // Channel B action field.
  logic [1:0]   wave_lo;               // Low mode bits, first control register.
  logic [1:0]   wave_hi;               // High mode bits, second control register.
  logic [2:0]   clk_sel;               // Timer clock select.
  logic [3:0]   wave_shape_select;     // Assembled mode code.
  logic [15:0]  count_value;           // Counter.
  logic [15:0]  capture_hold_value;    // Capture register, also a top source.
  logic [15:0]  buf_a;                 // Software copy of channel A compare.
  logic [15:0]  buf_b;                 // Software copy of channel B compare.
  logic [15:0]  chan_a_match_value;    // Active channel A compare.
  logic [15:0]  chan_b_match_value;    // Active channel B compare.
  logic [2:0]   status;                // Sticky event bits.
  logic [2:0]   mask;                  // Interrupt mask.
  t16oc_dir_t   dir;                   // Count direction.
  logic [9:0]   pre_cnt;               // Prescaler.
  logic         tick;                  // Timer clock enable.
  t16oc_class_t wave_class;            // Decoded family.
  logic         is_pfc;                // Frequency-correct dual slope.
  logic [15:0]  top;                   // Current top value.
  logic         at_top;                // Counter equals top.
  logic         at_bottom;             // Counter equals zero.
  logic         at_max;                // Counter equals all ones.
  logic         match_a;               // Channel A compare hit.
  logic         match_b;               // Channel B compare hit.
  logic         load_buf;              // Active compares reload now.
  logic         wrap_evt;              // Wrap flag event.
  logic         toggle_ok_a;           // Channel A toggle permitted.
  logic [2:0]   evt;                   // Events into status.
  logic         wr_a;                  // Write strobe decodes.
  logic         wr_b;
  logic [2:0]   w1c;                   // Status bits cleared by software.

  // The mode code is split over two registers and joined here.
  assign wave_shape_select = {wave_hi, wave_lo};

  // Strobe decodes shared by several processes.
  assign wr_a = reg_wr && reg_addr == `T16OC_OFS_CTRL_A;
  assign wr_b = reg_wr && reg_addr == `T16OC_OFS_CTRL_B;

  // Decode the family, the top source and the buffer policy.
  always_comb
  begin
    wave_class = t16oc_plain;
    is_pfc     = 1'b0;
    top        = `T16OC_TOP_MAX;
    case (wave_shape_select)
      4'h0: top = `T16OC_TOP_MAX;
      4'h1:
      begin
        wave_class = t16oc_dual;
        top        = `T16OC_TOP_8BIT;
      end
      4'h2:
      begin
        wave_class = t16oc_dual;
        top        = `T16OC_TOP_9BIT;
      end
      4'h3:
      begin
        wave_class = t16oc_dual;
        top        = `T16OC_TOP_10BIT;
      end
      4'h4:
      begin
        wave_class = t16oc_ctc;
        top        = chan_a_match_value;
      end
      4'h5:
      begin
        wave_class = t16oc_fast;
        top        = `T16OC_TOP_8BIT;
      end
      4'h6:
      begin
        wave_class = t16oc_fast;
        top        = `T16OC_TOP_9BIT;
      end
      4'h7:
      begin
        wave_class = t16oc_fast;
        top        = `T16OC_TOP_10BIT;
      end
      4'h8:
      begin
        wave_class = t16oc_dual;
        is_pfc     = 1'b1;
        top        = capture_hold_value;
      end
      4'h9:
      begin
        wave_class = t16oc_dual;
        is_pfc     = 1'b1;
        top        = chan_a_match_value;
      end
      4'ha:
      begin
        wave_class = t16oc_dual;
        top        = capture_hold_value;
      end
      4'hb:
      begin
        wave_class = t16oc_dual;
        top        = chan_a_match_value;
      end
      4'hc:
      begin
        wave_class = t16oc_ctc;
        top        = capture_hold_value;
      end
      4'he:
      begin
        wave_class = t16oc_fast;
        top        = capture_hold_value;
      end
      4'hf:
      begin
        wave_class = t16oc_fast;
        top        = chan_a_match_value;
      end
      // The reserved code behaves as a plain counter.
      default: top = `T16OC_TOP_MAX;
    endcase
  end

  // Compare and position events, all taken from the value before the tick.
  assign at_top    = count_value == top;
  assign at_bottom = count_value == 16'h0000;
  assign at_max    = count_value == `T16OC_TOP_MAX;
  assign match_a   = count_value == chan_a_match_value;
  assign match_b   = count_value == chan_b_match_value;

  // Among the fast and dual modes, toggle on A exists only in modes 9, b, e and f.
  assign toggle_ok_a = (wave_class == t16oc_fast && wave_shape_select[3:1] == 3'h7)
                    || (wave_class == t16oc_dual && wave_shape_select[3] && wave_shape_select[0]);

  // Buffered compares reload at top or bottom, immediately otherwise.
  always_comb
  begin
    load_buf = 1'b0;
    wrap_evt = 1'b0;
    case (wave_class)
      t16oc_fast:
      begin
        load_buf = at_bottom;
        wrap_evt = at_top;
      end
      t16oc_dual:
      begin
        load_buf = is_pfc ? (at_bottom && dir == t16oc_down) : (at_top && dir == t16oc_up);
        wrap_evt = at_bottom && dir == t16oc_down;
      end
      default:
      begin
        load_buf = 1'b1;
        wrap_evt = at_max;
      end
    endcase
  end

  // Prescaler: a free divider whose low bits pick the tick rate.
  always_ff @(posedge clk)
  begin
    if (rst)
      pre_cnt <= 10'h000;
    else
      pre_cnt <= pre_cnt + 10'h001;
  end

  // Tick selection; external clock codes are not wired and stop the timer.
  always_comb
  begin
    case (clk_sel)
      `T16OC_CS_DIV1:    tick = 1'b1;
      `T16OC_CS_DIV8:    tick = &pre_cnt[2:0];
      `T16OC_CS_DIV64:   tick = &pre_cnt[5:0];
      `T16OC_CS_DIV256:  tick = &pre_cnt[7:0];
      `T16OC_CS_DIV1024: tick = &pre_cnt;
      default:           tick = 1'b0;
    endcase
  end

  // Control registers; bits 3:2 of the first are not stored.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      chan_a_output_action <= 2'h0;
      chan_b_output_action <= 2'h0;
      wave_lo              <= 2'h0;
      wave_hi              <= 2'h0;
      clk_sel              <= `T16OC_CS_STOP;
    end
    else
    begin
      if (wr_a)
      begin
        chan_a_output_action <= reg_wdata[`T16OC_ACT_A_HI:`T16OC_ACT_A_LO];
        chan_b_output_action <= reg_wdata[`T16OC_ACT_B_HI:`T16OC_ACT_B_LO];
        wave_lo              <= reg_wdata[1:0];
      end
      if (wr_b)
      begin
        wave_hi <= reg_wdata[`T16OC_WAVE_HI_HI:`T16OC_WAVE_HI_LO];
        clk_sel <= reg_wdata[2:0];
      end
    end
  end

  // Software copies of compares and the capture register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      buf_a              <= `T16OC_WORD_RESET;
      buf_b              <= `T16OC_WORD_RESET;
      capture_hold_value <= `T16OC_WORD_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `T16OC_OFS_MA_LO:  buf_a[7:0]               <= reg_wdata;
        `T16OC_OFS_MA_HI:  buf_a[15:8]              <= reg_wdata;
        `T16OC_OFS_MB_LO:  buf_b[7:0]               <= reg_wdata;
        `T16OC_OFS_MB_HI:  buf_b[15:8]              <= reg_wdata;
        `T16OC_OFS_CAP_LO: capture_hold_value[7:0]  <= reg_wdata;
        `T16OC_OFS_CAP_HI: capture_hold_value[15:8] <= reg_wdata;
        default:           buf_a                    <= buf_a;
      endcase
    end
  end

  // Active compares; double buffering keeps PWM periods glitch free.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      chan_a_match_value <= `T16OC_WORD_RESET;
      chan_b_match_value <= `T16OC_WORD_RESET;
    end
    else if (wave_class == t16oc_plain || wave_class == t16oc_ctc || (tick && load_buf))
    begin
      chan_a_match_value <= buf_a;
      chan_b_match_value <= buf_b;
    end
  end

  // Counter and direction; a software write beats the tick.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_value <= `T16OC_WORD_RESET;
      dir         <= t16oc_up;
    end
    else if (reg_wr && reg_addr == `T16OC_OFS_CNT_LO)
      count_value[7:0] <= reg_wdata;
    else if (reg_wr && reg_addr == `T16OC_OFS_CNT_HI)
      count_value[15:8] <= reg_wdata;
    else if (tick)
    begin
      if (wave_class == t16oc_dual)
      begin
        if (dir == t16oc_up && (at_top || at_max))
        begin
          dir         <= t16oc_down;
          count_value <= count_value - 16'h0001;
        end
        else if (dir == t16oc_down && at_bottom)
        begin
          dir         <= t16oc_up;
          count_value <= count_value + 16'h0001;
        end
        else
          count_value <= (dir == t16oc_up) ? count_value + 16'h0001 : count_value - 16'h0001;
      end
      else
      begin
        dir         <= t16oc_up;
        count_value <= (wave_class != t16oc_plain && at_top) ? 16'h0000 : count_value + 16'h0001;
      end
    end
  end

  // Sticky status: an event in the clearing cycle still lands.
  assign evt = tick ? {match_b, match_a, wrap_evt} : 3'h0;
  assign w1c = (reg_wr && reg_addr == `T16OC_OFS_STATUS) ? reg_wdata[2:0] : 3'h0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status <= 3'h0;
      mask   <= 3'h0;
    end
    else
    begin
      status <= (status & ~w1c) | evt;
      if (reg_wr && reg_addr == `T16OC_OFS_MASK)
        mask <= reg_wdata[2:0];
    end
  end

  // Pin takeover and interrupt, registered for clean outputs.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      chan_a_pin_takeover <= 1'b0;
      chan_b_pin_takeover <= 1'b0;
      timer_irq           <= 1'b0;
    end
    else
    begin
      chan_a_pin_takeover <= |chan_a_output_action;
      chan_b_pin_takeover <= |chan_b_output_action;
      timer_irq           <= |(status & mask);
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk)
  begin
    if (rst || !reg_rd)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        `T16OC_OFS_CTRL_A: reg_rdata <= {chan_a_output_action, chan_b_output_action, 2'b00, wave_lo};
        `T16OC_OFS_CTRL_B: reg_rdata <= {3'b000, wave_hi, clk_sel};
        `T16OC_OFS_CNT_LO: reg_rdata <= count_value[7:0];
        `T16OC_OFS_CNT_HI: reg_rdata <= count_value[15:8];
        `T16OC_OFS_CAP_LO: reg_rdata <= capture_hold_value[7:0];
        `T16OC_OFS_CAP_HI: reg_rdata <= capture_hold_value[15:8];
        `T16OC_OFS_MA_LO:  reg_rdata <= buf_a[7:0];
        `T16OC_OFS_MA_HI:  reg_rdata <= buf_a[15:8];
        `T16OC_OFS_MB_LO:  reg_rdata <= buf_b[7:0];
        `T16OC_OFS_MB_HI:  reg_rdata <= buf_b[15:8];
        `T16OC_OFS_STATUS: reg_rdata <= {5'h00, status};
        `T16OC_OFS_MASK:   reg_rdata <= {5'h00, mask};
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  // Output channels; B can never toggle in the fast and dual families.
  t16oc_wave_unit u_wave_a (
    .clk          (clk),
    .rst          (rst),
    .tick         (tick),
    .wave_class   (wave_class),
    .action       (chan_a_output_action),
    .toggle_ok    (toggle_ok_a),
    .match        (match_a),
    .at_bottom    (at_bottom),
    .match_is_top (chan_a_match_value == top),
    .dir          (dir),
    .wave         (chan_a_wave_out)
  );

  t16oc_wave_unit u_wave_b (
    .clk          (clk),
    .rst          (rst),
    .tick         (tick),
    .wave_class   (wave_class),
    .action       (chan_b_output_action),
    .toggle_ok    (1'b0),
    .match        (match_b),
    .at_bottom    (at_bottom),
    .match_is_top (chan_b_match_value == top),
    .dir          (dir),
    .wave         (chan_b_wave_out)
  );

  // Checks.
  sequence s_fast_tick;
    wave_class == t16oc_fast && tick;
  endsequence
  sequence s_dual_match_a;
    wave_class == t16oc_dual && tick && match_a;
  endsequence

  AST_TAKEOVER_A: assert property (@(posedge clk) disable iff (rst)
    (wr_a ##1 !wr_a) |=> (chan_a_pin_takeover == |$past(reg_wdata[7:6], 2))) else $error("A takeover wrong");
  AST_TAKEOVER_B: assert property (@(posedge clk) disable iff (rst)
    (wr_a ##1 !wr_a) |=> (chan_b_pin_takeover == |$past(reg_wdata[5:4], 2))) else $error("B takeover wrong");
  AST_PLAIN_LOW: assert property (@(posedge clk) disable iff (rst)
    (wave_class == t16oc_plain && tick && match_a && chan_a_output_action == 2'b10) |=> !chan_a_wave_out)
    else $error("plain clear failed");
  AST_FAST_NO_TOGGLE: assert property (@(posedge clk) disable iff (rst)
    (s_fast_tick and chan_b_output_action == 2'b01) |=> $stable(chan_b_wave_out)) else $error("B toggled");
  AST_FAST_BOTTOM: assert property (@(posedge clk) disable iff (rst)
    (s_fast_tick and chan_a_output_action == 2'b10 && at_bottom && !match_a) |=> chan_a_wave_out)
    else $error("bottom set failed");
  AST_FAST_INV: assert property (@(posedge clk) disable iff (rst)
    (s_fast_tick and chan_a_output_action == 2'b11 && match_a && chan_a_match_value != top) |=> chan_a_wave_out)
    else $error("inverting set failed");
  AST_TOP_IGNORED: assert property (@(posedge clk) disable iff (rst)
    (s_fast_tick and chan_b_output_action[1] && match_b && at_top && !at_bottom) |=> $stable(chan_b_wave_out))
    else $error("top match acted");
  AST_DUAL_DOWN: assert property (@(posedge clk) disable iff (rst)
    (s_dual_match_a and chan_a_output_action == 2'b10 && dir == t16oc_down) |=> chan_a_wave_out)
    else $error("down set failed");
  AST_DUAL_UP: assert property (@(posedge clk) disable iff (rst)
    (s_dual_match_a and chan_a_output_action == 2'b11 && dir == t16oc_up) |=> chan_a_wave_out)
    else $error("up set failed");
  AST_MODE_JOIN: assert property (@(posedge clk) disable iff (rst)
    (wr_a ##1 !wr_a ##1 wr_b) |=> wave_shape_select == {$past(reg_wdata[4:3]), $past(reg_wdata[1:0], 3)})
    else $error("mode join wrong");
  AST_PFC_WRAP: assert property (@(posedge clk) disable iff (rst)
    (is_pfc && tick && at_bottom && dir == t16oc_down && !w1c[0]) |=> status[0] && chan_a_match_value == $past(buf_a))
    else $error("wrap and load apart");
  AST_CTRL_READ: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == `T16OC_OFS_CTRL_A) |=> reg_rdata[3:2] == 2'b00) else $error("reserved bits set");

endmodule : t16oc_top

// [pkg/t16oc_consts.svh]
`ifndef T16OC_CONSTS_SVH
`define T16OC_CONSTS_SVH
// Register byte offsets.
`define T16OC_OFS_CTRL_A    8'h80
`define T16OC_OFS_CTRL_B    8'h81
`define T16OC_OFS_CNT_LO    8'h84
`define T16OC_OFS_CNT_HI    8'h85
`define T16OC_OFS_CAP_LO    8'h86
`define T16OC_OFS_CAP_HI    8'h87
`define T16OC_OFS_MA_LO     8'h88
`define T16OC_OFS_MA_HI     8'h89
`define T16OC_OFS_MB_LO     8'h8a
`define T16OC_OFS_MB_HI     8'h8b
`define T16OC_OFS_STATUS    8'h8c
`define T16OC_OFS_MASK      8'h8d
// Field positions.
`define T16OC_ACT_A_HI      7
`define T16OC_ACT_A_LO      6
`define T16OC_ACT_B_HI      5
`define T16OC_ACT_B_LO      4
`define T16OC_WAVE_HI_HI    4
`define T16OC_WAVE_HI_LO    3
`define T16OC_ST_WRAP       0
`define T16OC_ST_MATCH_A    1
`define T16OC_ST_MATCH_B    2
// Reset values.
`define T16OC_CTRL_RESET    8'h00
`define T16OC_WORD_RESET    16'h0000
// Fixed top values.
`define T16OC_TOP_MAX       16'hffff
`define T16OC_TOP_8BIT      16'h00ff
`define T16OC_TOP_9BIT      16'h01ff
`define T16OC_TOP_10BIT     16'h03ff
// Clock select codes.
`define T16OC_CS_STOP       3'h0
`define T16OC_CS_DIV1       3'h1
`define T16OC_CS_DIV8       3'h2
`define T16OC_CS_DIV64      3'h3
`define T16OC_CS_DIV256     3'h4
`define T16OC_CS_DIV1024    3'h5
`endif

// [pkg/t16oc_pkg.sv]
package t16oc_pkg;
  // Waveform family that steers the output action decode.
  typedef enum logic [1:0] {
    t16oc_plain,
    t16oc_ctc,
    t16oc_fast,
    t16oc_dual
  } t16oc_class_t;
  // Count direction of the dual-slope families.
  typedef enum logic {
    t16oc_up,
    t16oc_down
  } t16oc_dir_t;
endpackage : t16oc_pkg

// [verilog/t16oc_wave_unit.sv]
`timescale 1ns/1ps
// One compare output channel: decodes its action field per waveform family.
module t16oc_wave_unit
  import t16oc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire t16oc_class_t wave_class,
  input  wire logic [1:0]   action,
  input  wire logic         toggle_ok,
  input  wire logic         match,
  input  wire logic         at_bottom,
  input  wire logic         match_is_top,
  input  wire t16oc_dir_t   dir,
  output logic              wave
);

  // The output latch moves only on timer ticks; the counter also moves on software writes.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wave <= 1'b0;
    end
    else if (tick && action != 2'b00)
    begin
      case (wave_class)
        t16oc_fast:
        begin
          // Toggle only where the mode allows it for this channel.
          if (action == 2'b01)
          begin
            if (toggle_ok && match)
              wave <= ~wave;
          end
          // A match equal to top is dropped; bottom still acts.
          else if (match && !match_is_top)
            wave <= action[0];
          else if (at_bottom)
            wave <= ~action[0];
        end
        t16oc_dual:
        begin
          if (action == 2'b01)
          begin
            if (toggle_ok && match)
              wave <= ~wave;
          end
          else if (match)
          begin
            // Direction decides the sense, so pulses stay centred.
            wave <= (dir == t16oc_up) ? action[0] : ~action[0];
          end
        end
        default:
        begin
          // Normal and clear-on-match families.
          if (match)
          begin
            if (action == 2'b01)
              wave <= ~wave;
            else
              wave <= action[0];
          end
        end
      endcase
    end
  end

endmodule : t16oc_wave_unit

// [dv/t16oc_pin_model.sv]
`timescale 1ns/1ps
// Port pad with a direction bit; a pull-up holds it high while released.
module t16oc_pin_model
(
  input  wire logic dir_out,   // Direction bit, high selects output.
  input  wire logic takeover,  // Compare unit owns the pad.
  input  wire logic wave,      // Compare output level.
  input  wire logic port_data, // Ordinary port data.
  output logic      pin        // Pad level.
);
  // The driver is off unless the direction is output, so nothing of the wave leaks.
  always_comb
  begin
    if (!dir_out)
      pin = 1'b1;
    else if (takeover)
      pin = wave;
    else
      pin = port_data;
  end
endmodule : t16oc_pin_model

// [dv/tb.sv]
`timescale 1ns/1ps
// Bench: bus tasks note expected reads in a queue; a monitor compares them.
module tb;
  logic       clk = 1'b0;       // System clock.
  logic       rst = 1'b1;       // Synchronous reset.
  logic [7:0] reg_addr = 8'h00; // Bus address.
  logic [7:0] reg_wdata = 8'h00; // Bus write data.
  logic       reg_wr = 1'b0;    // Write strobe.
  logic       reg_rd = 1'b0;    // Read strobe.
  logic       rd_d = 1'b0;      // Read data is due now.
  logic       dir = 1'b0;       // Pad direction bit.
  logic       port_d = 1'b0;    // Ordinary port data.
  logic [7:0] reg_rdata;        // Read data.
  logic       wa, wb, take_a, take_b, irq, pa, pb; // Outputs and pads.
  logic [7:0] exp_q[$];         // Expected read data, oldest first.
  int         n_errors = 0;     // Mismatches.
  int         checked = 0;      // Comparisons.
  int         cyc = 0;          // Cycle count.
  int         k0 = 0;           // Cycle at which the counter started.

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  t16oc_top i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_a_wave_out(wa), .chan_b_wave_out(wb),
    .chan_a_pin_takeover(take_a), .chan_b_pin_takeover(take_b), .timer_irq(irq));
  t16oc_pin_model i_pin_a (.dir_out(dir), .takeover(take_a), .wave(wa), .port_data(port_d), .pin(pa));
  t16oc_pin_model i_pin_b (.dir_out(dir), .takeover(take_b), .wave(wb), .port_data(port_d), .pin(pb));

  // Byte compare; case equality so an unknown never matches.
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  // Single bit compare.
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp({7'h00, got}, {7'h00, exp}, what);
  endtask : cmp_bit

  // Write; the idle cycle after it keeps strobe changes apart.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Read; the expected byte is noted for the monitor.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd

  // Read data stands only in the cycle after the strobe.
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      cmp(reg_rdata, exp_q.pop_front(), "read data");
  end

  // Fresh reset, compares, mode, then start the counter at full rate.
  task automatic setup(input logic [3:0] mode, input logic [1:0] code, input logic [7:0] ma, mb, cap);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(8'h88, ma);
    wr(8'h8a, mb);
    wr(8'h86, cap);
    wr(8'h80, {code, code, 2'b00, mode[1:0]});
    wr(8'h81, {3'h0, mode[3:2], 3'h1});
    k0 = cyc;
  endtask : setup

  // Pad level predicted from the counter position; samples near events are skipped.
  task automatic pwm(input logic [3:0] mode, input logic [1:0] code, input int top, input logic [7:0] mb,
                     input logic dual);
    logic [7:0] ma;
    int p;
    int k;
    int c;
    ma = 8'h20 + 8'($urandom % 32);
    setup(mode, code, ma, mb, top[7:0]);
    // Dual slope visits top and bottom once each, so a period is twice the top.
    p = dual ? 2 * top : top + 1;
    repeat (p + top + 8) @(posedge clk);
    repeat (12)
    begin
      repeat (1 + $urandom % 40) @(posedge clk);
      k = (cyc - k0) % p;
      c = (dual && k > top) ? p - k : k;
      if (c > 8 && (c > ma + 8 || c + 8 < ma))
        cmp_bit(pa, (c < ma) ^ code[0], "wave a");
      if (c > 8 && (c > mb + 8 || c + 8 < mb))
        cmp_bit(pb, (c < mb) ^ code[0], "wave b");
    end
    $display("pwm mode %0d done", mode);
  endtask : pwm

  // Action code 01: channel A toggles once a period only if asked, B holds.
  task automatic tog(input logic [3:0] mode, input logic tg);
    logic a0;
    logic b0;
    setup(mode, 2'b01, 8'h40, 8'h20, 8'h40);
    repeat (300) @(posedge clk);
    a0 = pa;
    b0 = pb;
    repeat (65) @(posedge clk);
    cmp_bit(pa, a0 ^ tg, "toggle a");
    cmp_bit(pb, b0, "hold b");
    $display("toggle mode %0d done", mode);
  endtask : tog

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // A hang counts as a mismatch.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  initial
  begin
    void'($urandom(72519));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h80, 8'h00);
    rd(8'h81, 8'h00);
    wr(8'h80, 8'hff);
    rd(8'h80, 8'hf3);
    rd(8'h9f, 8'h00);
    port_d <= 1'($urandom);
    repeat (2) @(posedge clk);
    cmp_bit(take_a, 1'b1, "takeover a");
    cmp_bit(take_b, 1'b1, "takeover b");
    cmp_bit(pa, 1'b1, "released pad");
    dir <= 1'b1;
    wr(8'h80, 8'h00);
    @(posedge clk);
    cmp_bit(pa, port_d, "port pad");
    $display("register test done");
    // Normal mode: set, clear and toggle on match, with the match interrupt.
    setup(4'h0, 2'b11, 8'h20, 8'hf0, 8'h00);
    wr(8'h8d, 8'h02);
    repeat (48) @(posedge clk);
    cmp_bit(pa, 1'b1, "set on match");
    cmp_bit(pb, 1'b0, "no match b");
    cmp_bit(irq, 1'b1, "irq raised");
    rd(8'h8c, 8'h02);
    for (int i = 2; i > 0; i--)
    begin
      wr(8'h80, {i[1:0], 6'h00});
      wr(8'h84, 8'h01);
      repeat (48) @(posedge clk);
      cmp_bit(pa, i == 1, "match action");
    end
    wr(8'h8d, 8'h00);
    repeat (2) @(posedge clk);
    cmp_bit(irq, 1'b0, "irq masked");
    wr(8'h8d, 8'h02);
    repeat (2) @(posedge clk);
    cmp_bit(irq, 1'b1, "irq unmasked");
    wr(8'h8c, 8'h02);
    repeat (2) @(posedge clk);
    cmp_bit(irq, 1'b0, "irq cleared");
    rd(8'h8c, 8'h00);
    $display("normal mode test done");
    pwm(4'h5, 2'b10, 255, 8'h30, 1'b0);
    pwm(4'h5, 2'b11, 255, 8'h30, 1'b0);
    pwm(4'he, 2'b11, 64, 8'h40, 1'b0);
    pwm(4'h1, 2'b10, 255, 8'h90, 1'b1);
    pwm(4'ha, 2'b11, 96, 8'h50, 1'b1);
    pwm(4'h8, 2'b10, 96, 8'h50, 1'b1);
    tog(4'hf, 1'b1);
    tog(4'h5, 1'b0);
    tog(4'h8, 1'b0);
    tog(4'h9, 1'b1);
    finish_test();
  end
endmodule : tb
